// File: src/mode_sm_consts.svh
/*
 * constants of the operating-mode state machine: register offsets, field
 * positions, reset values and timing counts.
 * assumes a 100 MHz core clock and a plain address/strobe register port.
 */
`ifndef MODE_SM_CONSTS_SVH
`define MODE_SM_CONSTS_SVH

// register offsets (8-bit index)
`define OFS_MODE_CTRL 8'h01
`define OFS_HARDWARE_CONTROL_REG 8'h0e
`define OFS_WAKE_LVL 8'h44
`define OFS_SUP_STAT 8'h40
`define OFS_DEV_STAT 8'h43
`define OFS_SPI_FRAME 8'h7f

// field positions
`define MODE_LSB 6
`define MODE_MSB 7
`define HWCTRL_FAILCNT_BIT 6
`define HWCTRL_OVRST_BIT 3
`define WKLVL_PINCFG_BIT 6
`define SUP_POR_BIT 0
`define SUP_OV_BIT 1
`define DEV_FAILOUT_BIT 0
`define DEV_DEBUG_BIT 1
`define DEV_WDFAIL_LSB 2

// reset values
`define HARDWARE_CONTROL_REG_RST 16'h0000
// synchroniser reset levels, one bit per input: the debug pin idles high
`define SYNC_RST 8'h40

// timing: reset delay 10 ms, long open window 200 ms, config filter 2 us
`define RESET_DELAY_US 10000
`define RESET_DELAY_CYC ((`RESET_DELAY_US) * 100)
`define LONG_WINDOW_US 200000
`define LONG_WINDOW_CYC ((`LONG_WINDOW_US) * 100)
`define CFG_FILTER_NS 2000
`define CFG_FILTER_CYC (((`CFG_FILTER_NS) + 9) / 10)

`endif

// File: src/mode_sm_pkg.sv
/*
 * types of the operating-mode state machine.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package mode_sm_pkg;

	// the six operating modes
	typedef enum logic [2:0] {
		MODE_INIT = 3'b000,
		MODE_NORMAL = 3'b001,
		MODE_STOP = 3'b010,
		MODE_SLEEP = 3'b011,
		MODE_RESTART = 3'b100,
		MODE_FAILSAFE = 3'b101
	} op_mode_type;

	// mode request code written by software into the mode field
	typedef enum logic [1:0] {
		REQ_NORMAL = 2'b00,
		REQ_SLEEP = 2'b01,
		REQ_STOP = 2'b10,
		REQ_RESET = 2'b11
	} mode_req_type;

endpackage

// File: src/operating_mode_state_machine.sv
/*
 * operating-mode state machine: mode sequencing, hardware configuration
 * latch from the interrupt pin, watchdog-failure and overvoltage handling.
 * assumes a 16-bit frame decoder beside it that presents each received frame
 * as a register access, and supply/watchdog monitors that give level inputs
 * from other domains (they are synchronised here).
 */
// The placing of the registers and the plain strobed port were chosen for this implementation.
`include "mode_sm_consts.svh"
`timescale 1ns/1ps
`default_nettype none

module operating_mode_state_machine
	import mode_sm_pkg::*;
#(
	parameter int unsigned RESET_DELAY = `RESET_DELAY_CYC,
	parameter int unsigned LONG_WINDOW = `LONG_WINDOW_CYC
) (
	// clock and power-on reset
	input wire logic mclk,
	input wire logic rst_n,
	// register port, one 16-bit frame per access
	input wire logic [7:0] regAddr,
	input wire logic [15:0] regWdata,
	input wire logic regWr,
	input wire logic regRd,
	output logic [15:0] regRdata,
	// asynchronous monitors and pins
	input wire logic mainSupplyOk,
	input wire logic mainOvervoltage,
	input wire logic wdFailIn,
	input wire logic wdTrigger,
	input wire logic wakeEvent,
	input wire logic overtemp,
	input wire logic debugSelectPin_n,
	input wire logic intPinIn,
	// pin and supply controls
	output logic intPullDown,
	output logic resetOutput_n,
	output logic mainSupplyEn,
	output logic failOutputs,
	output logic debugMode,
	output logic wdHalt,
	output logic wakeAccepted,
	output logic [2:0] modeState
);

	localparam logic [24:0] RD_CNT = 25'(RESET_DELAY);
	localparam logic [24:0] LW_CNT = 25'(LONG_WINDOW); // 25 bits hold the full long window
	localparam logic [7:0] FLT_CNT = 8'(`CFG_FILTER_CYC);

	// two-stage synchronisers for every asynchronous input, one generate loop
	localparam int NSYNC = 8;
	localparam logic [NSYNC-1:0] SYNC_IDLE = `SYNC_RST; // idle levels, no false debug entry
	logic [NSYNC-1:0] asyncIn;
	logic [NSYNC-1:0] syncA_q;
	logic [NSYNC-1:0] syncB_q;
	assign asyncIn = {intPinIn, debugSelectPin_n, overtemp, wakeEvent, wdTrigger,
		wdFailIn, mainOvervoltage, mainSupplyOk};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			// first stage feeds only the second stage
			always_ff @(posedge mclk or negedge rst_n) begin
				if (!rst_n) begin
					syncA_q[gi] <= SYNC_IDLE[gi];
					syncB_q[gi] <= SYNC_IDLE[gi];
				end else begin
					syncA_q[gi] <= asyncIn[gi];
					syncB_q[gi] <= syncA_q[gi];
				end
			end
		end
	endgenerate
	logic supOk, ovIn, wdFail, wdTrig, wake, otIn, dbgPin_n, intPin;
	assign {intPin, dbgPin_n, otIn, wake, wdTrig, wdFail, ovIn, supOk} = syncB_q;

	// edge memory for event inputs
	logic wdFailPrev_q, ovPrev_q, wakePrev_q;
	logic wdFailEv, ovEv, wakeEv;
	assign wdFailEv = wdFail & ~wdFailPrev_q;
	assign ovEv = ovIn & ~ovPrev_q;
	assign wakeEv = wake & ~wakePrev_q;

	// state registers
	op_mode_type mode_q, mode_d;
	logic [24:0] timer_q, timer_d; // reset delay or long window counter
	logic [1:0] modeBits_q, modeBits_d; // software mode field
	logic failCntSel_q, failCntSel_d; // fail-count select
	logic ovRstEn_q, ovRstEn_d; // overvoltage reset enable
	logic porFlag_q, porFlag_d; // power-on flag
	logic ovFlag_q, ovFlag_d; // main overvoltage flag
	logic pinCfg_q, pinCfg_d; // latched pin config
	logic cfgLatched_q, cfgLatched_d; // config taken at least once
	logic [7:0] flt_q, flt_d; // stability filter count
	logic stable_q, stable_d; // pin held steady through a filter time
	logic fltLvl_q, fltLvl_d; // filtered pin level
	logic [1:0] wdFailCnt_q, wdFailCnt_d;
	logic failOut_q, failOut_d;
	logic debug_q, debug_d;
	logic resetOut_q, resetOut_d;
	logic pull_q, pull_d;
	logic wakeAcc_q, wakeAcc_d;
	logic [15:0] rdata_q, rdata_d;
	logic frameSeen;
	logic wdEvent;

	// any access counts as a received frame
	assign frameSeen = regWr | regRd;
	// a halted watchdog never fails; a missed long window counts as a failure
	assign wdEvent = ~debug_q & (wdFailEv |
		(mode_q == MODE_INIT && timer_q == 25'h0000000 && cfgLatched_q));

	// next-state logic for mode, configuration and flags
	always_comb begin
		logic goFail;
		logic goRestart;
		logic failNow;
		goFail = 1'b0;
		goRestart = 1'b0;
		failNow = 1'b0;
		mode_d = mode_q;
		timer_d = (timer_q != 25'h0000000) ? timer_q - 25'h0000001 : timer_q;
		modeBits_d = modeBits_q;
		failCntSel_d = failCntSel_q;
		ovRstEn_d = ovRstEn_q;
		porFlag_d = porFlag_q;
		ovFlag_d = ovFlag_q;
		pinCfg_d = pinCfg_q;
		cfgLatched_d = cfgLatched_q;
		flt_d = flt_q;
		stable_d = stable_q;
		fltLvl_d = fltLvl_q;
		wdFailCnt_d = wdFailCnt_q;
		failOut_d = failOut_q;
		debug_d = debug_q;
		resetOut_d = resetOut_q;
		pull_d = pull_q;
		wakeAcc_d = 1'b0;

		// continuous filter while the pull-down is active
		if (pull_q) begin
			if (intPin != fltLvl_q) begin
				fltLvl_d = intPin;
				flt_d = 8'h00;
				stable_d = 1'b0;
			end else if (flt_q >= FLT_CNT - 8'h01) begin
				stable_d = 1'b1;
			end else begin
				flt_d = flt_q + 8'h01;
			end
		end

		// debug mode is sampled only while in init
		if (mode_q == MODE_INIT && !dbgPin_n) debug_d = 1'b1;

		// software writes: one frame sets a register
		if (regWr) begin
			case (regAddr)
				`OFS_MODE_CTRL: modeBits_d = regWdata[`MODE_MSB:`MODE_LSB];
				`OFS_HARDWARE_CONTROL_REG: begin
					failCntSel_d = regWdata[`HWCTRL_FAILCNT_BIT];
					ovRstEn_d = regWdata[`HWCTRL_OVRST_BIT];
				end
				`OFS_SUP_STAT: begin
					// write one to clear; an arriving event wins below
					if (regWdata[`SUP_POR_BIT]) porFlag_d = 1'b0;
					if (regWdata[`SUP_OV_BIT]) ovFlag_d = 1'b0;
				end
				default: ;
			endcase
		end

		// overvoltage: flag always, action only when enabled
		if (ovEv) begin
			ovFlag_d = 1'b1;
			if (ovRstEn_q && (mode_q == MODE_NORMAL || mode_q == MODE_STOP)) begin
				failNow = 1'b1;
				if (pinCfg_q) goRestart = 1'b1;
				else goFail = 1'b1;
			end
		end

		// watchdog failure mapping by configuration
		if (wdEvent && mode_q != MODE_RESTART && mode_q != MODE_FAILSAFE
			&& mode_q != MODE_SLEEP) begin
			if (wdFailCnt_q != 2'b11) wdFailCnt_d = wdFailCnt_q + 2'b01;
			if (failCntSel_q || wdFailCnt_q != 2'b00) failNow = 1'b1;
			if (pinCfg_q) goRestart = 1'b1;
			else if (!failCntSel_q && wdFailCnt_q == 2'b00) goRestart = 1'b1;
			else goFail = 1'b1;
		end
		if (failNow) failOut_d = 1'b1;

		// mode sequencing
		case (mode_q)
			MODE_INIT: begin
				// a trigger inside the long window keeps it from running out
				if (wdTrig && cfgLatched_q) timer_d = LW_CNT;
				if (wakeEv) wakeAcc_d = 1'b0;
				if (goRestart || goFail) begin
					mode_d = MODE_RESTART;
				end else if (frameSeen && cfgLatched_q) begin
					mode_d = MODE_NORMAL;
				end
			end
			MODE_NORMAL, MODE_STOP: begin
				wakeAcc_d = wakeEv;
				if (goFail) mode_d = MODE_FAILSAFE;
				else if (goRestart || !supOk) mode_d = MODE_RESTART;
				else if (modeBits_q == REQ_SLEEP) mode_d = MODE_SLEEP;
				else if (modeBits_q == REQ_STOP) mode_d = MODE_STOP;
				else if (modeBits_q == REQ_RESET) mode_d = MODE_RESTART;
				else mode_d = MODE_NORMAL;
			end
			MODE_SLEEP: begin
				if (wakeEv) begin
					wakeAcc_d = 1'b1;
					mode_d = MODE_RESTART;
				end
			end
			MODE_FAILSAFE: begin
				// supply off until a wake or the end of overtemperature
				if (wakeEv || !otIn) begin
					wakeAcc_d = wakeEv;
					mode_d = MODE_RESTART;
				end
			end
			MODE_RESTART: begin
				modeBits_d = 2'b00;
				// leave only once supply is good and the delay has run out
				if (!supOk) timer_d = RD_CNT;
				else if (timer_q == 25'h0000000) mode_d = MODE_NORMAL;
			end
			default: mode_d = MODE_INIT;
		endcase

		// entering restart: reset asserted, delay reloaded
		if (mode_d == MODE_RESTART && mode_q != MODE_RESTART) begin
			timer_d = RD_CNT;
			resetOut_d = 1'b0;
			modeBits_d = 2'b00;
			if (porFlag_q) begin
				pull_d = 1'b1;
				flt_d = 8'h00;
				stable_d = 1'b0;
				fltLvl_d = intPin;
			end
		end
		if (mode_q == MODE_FAILSAFE) resetOut_d = 1'b0;

		// power-up reset delay before the first release
		if (mode_q == MODE_INIT && !cfgLatched_q) begin
			if (!supOk) timer_d = RD_CNT;
			else if (timer_q != 25'h0000000) timer_d = timer_q - 25'h0000001;
			else begin
				resetOut_d = 1'b1;
				timer_d = LW_CNT;
			end
		end

		// leaving restart releases the reset output
		if (mode_q == MODE_RESTART && mode_d == MODE_NORMAL) resetOut_d = 1'b1;

		// rising edge of the reset output latches the configuration
		if (resetOut_d && !resetOut_q && pull_q) begin
			pinCfg_d = stable_d ? fltLvl_d : 1'b0;
			cfgLatched_d = 1'b1;
			pull_d = 1'b0;
		end
	end

	// readback, one cycle after the read strobe
	always_comb begin
		rdata_d = 16'h0000;
		if (regRd) begin
			case (regAddr)
				`OFS_MODE_CTRL: rdata_d[`MODE_MSB:`MODE_LSB] = modeBits_q;
				`OFS_HARDWARE_CONTROL_REG: begin
					rdata_d[`HWCTRL_FAILCNT_BIT] = failCntSel_q;
					rdata_d[`HWCTRL_OVRST_BIT] = ovRstEn_q;
				end
				`OFS_WAKE_LVL: rdata_d[`WKLVL_PINCFG_BIT] = pinCfg_q;
				`OFS_SUP_STAT: begin
					rdata_d[`SUP_POR_BIT] = porFlag_q;
					rdata_d[`SUP_OV_BIT] = ovFlag_q;
				end
				`OFS_DEV_STAT: begin
					rdata_d[`DEV_FAILOUT_BIT] = failOut_q;
					rdata_d[`DEV_DEBUG_BIT] = debug_q;
					rdata_d[`DEV_WDFAIL_LSB+1:`DEV_WDFAIL_LSB] = wdFailCnt_q;
					rdata_d[10:8] = mode_q;
				end
				default: rdata_d = 16'h0000;
			endcase
		end
	end

	// register everything; power-on reset starts in init with supply on
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			mode_q <= MODE_INIT;
			timer_q <= RD_CNT;
			modeBits_q <= 2'b00;
			failCntSel_q <= 1'(`HARDWARE_CONTROL_REG_RST >> `HWCTRL_FAILCNT_BIT);
			ovRstEn_q <= 1'b0;
			porFlag_q <= 1'b1;
			ovFlag_q <= 1'b0;
			pinCfg_q <= 1'b0;
			cfgLatched_q <= 1'b0;
			flt_q <= 8'h00;
			stable_q <= 1'b0;
			fltLvl_q <= 1'b0;
			wdFailCnt_q <= 2'b00;
			failOut_q <= 1'b0;
			debug_q <= 1'b0;
			resetOut_q <= 1'b0;
			pull_q <= 1'b1;
			wakeAcc_q <= 1'b0;
			rdata_q <= 16'h0000;
			wdFailPrev_q <= 1'b0;
			ovPrev_q <= 1'b0;
			wakePrev_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			timer_q <= timer_d;
			modeBits_q <= modeBits_d;
			failCntSel_q <= failCntSel_d;
			ovRstEn_q <= ovRstEn_d;
			porFlag_q <= porFlag_d;
			ovFlag_q <= ovFlag_d;
			pinCfg_q <= pinCfg_d;
			cfgLatched_q <= cfgLatched_d;
			flt_q <= flt_d;
			stable_q <= stable_d;
			fltLvl_q <= fltLvl_d;
			wdFailCnt_q <= wdFailCnt_d;
			failOut_q <= failOut_d;
			debug_q <= debug_d;
			resetOut_q <= resetOut_d;
			pull_q <= pull_d;
			wakeAcc_q <= wakeAcc_d;
			rdata_q <= rdata_d;
			wdFailPrev_q <= wdFail;
			ovPrev_q <= ovIn;
			wakePrev_q <= wake;
		end
	end

	// output flops: each mirrors a state register of the same cycle, mainSupplyEn a decode of the mode, except that intPullDown resets low while pull_q resets high
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) begin
			regRdata <= 16'h0000;
			intPullDown <= 1'b0;
			resetOutput_n <= 1'b0;
			mainSupplyEn <= 1'b1;
			failOutputs <= 1'b0;
			debugMode <= 1'b0;
			wdHalt <= 1'b0;
			wakeAccepted <= 1'b0;
			modeState <= 3'b000;
		end else begin
			regRdata <= rdata_d;
			intPullDown <= pull_d;
			resetOutput_n <= resetOut_d;
			mainSupplyEn <= (mode_d != MODE_SLEEP) && (mode_d != MODE_FAILSAFE);
			failOutputs <= failOut_d;
			debugMode <= debug_d;
			wdHalt <= debug_d;
			wakeAccepted <= wakeAcc_d;
			modeState <= mode_d;
		end
	end

endmodule

`default_nettype wire

// File: sim/mode_sm_assertions.sv
/*
 * concurrent checks on the mode state machine's ports.
 * assumes it is bound into operating_mode_state_machine with its delay count.
 */
`timescale 1ns/1ps
`default_nettype none

module mode_sm_assertions
	import mode_sm_pkg::*;
#(
	parameter int unsigned RESET_DELAY = 50
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_n,
	// register port
	input wire logic regWr,
	input wire logic regRd,
	input wire logic [15:0] regRdata,
	// pin and mode outputs
	input wire logic intPullDown,
	input wire logic resetOutput_n,
	input wire logic mainSupplyEn,
	input wire logic failOutputs,
	input wire logic debugMode,
	input wire logic wdHalt,
	input wire logic wakeAccepted,
	input wire logic [2:0] modeState
);
	default clocking @(posedge mclk); endclocking
	default disable iff (!rst_n);

	logic [31:0] lowCnt_d; // next low-time count
	logic [31:0] lowCnt_q; // cycles the reset output has been low

	// counting the low time lets a release be held against the delay
	always_comb begin
		lowCnt_d = resetOutput_n ? 32'h0 : lowCnt_q + 32'h1;
	end
	always_ff @(posedge mclk or negedge rst_n) begin
		if (!rst_n) lowCnt_q <= 32'h0;
		else lowCnt_q <= lowCnt_d;
	end

	// a frame seen once the reset output is released
	sequence sFrameInInit;
		(regWr || regRd) && modeState == MODE_INIT && resetOutput_n;
	endsequence
	// normal mode reached a few cycles later
	sequence sReachNormal;
		##[1:4] modeState == MODE_NORMAL;
	endsequence

	a_frame_leaves_init: assert property (sFrameInInit |-> sReachNormal)
		else $error("frame in init did not reach normal");
	a_restart_holds_reset: assert property (modeState == MODE_RESTART |-> !resetOutput_n)
		else $error("reset released in restart");
	a_failsafe_supply_off: assert property (modeState == MODE_FAILSAFE |-> !mainSupplyEn)
		else $error("supply on in fail-safe");
	a_init_drops_wake: assert property (modeState == MODE_INIT |-> !wakeAccepted)
		else $error("wake accepted in init");
	a_mode_in_range: assert property (modeState <= MODE_FAILSAFE)
		else $error("mode code out of range");
	a_release_after_delay: assert property ($rose(resetOutput_n) |-> lowCnt_q >= RESET_DELAY)
		else $error("reset released too early");
	a_pull_before_release: assert property ($rose(resetOutput_n) |-> $past(intPullDown))
		else $error("no pull-down before release");
	a_release_into_normal: assert property ($rose(resetOutput_n) |-> modeState inside {MODE_INIT, MODE_NORMAL})
		else $error("release outside init or normal");
	a_read_data_idle: assert property (!regRd |=> regRdata == 16'h0000)
		else $error("read data without a read");
	a_fail_out_sticky: assert property (failOutputs |=> failOutputs)
		else $error("fail outputs dropped");
	a_debug_halts_wd: assert property (debugMode |-> wdHalt)
		else $error("debug without watchdog halt");
	a_debug_from_init: assert property ($rose(debugMode) |-> $past(modeState) == MODE_INIT)
		else $error("debug entered outside init");
endmodule

bind operating_mode_state_machine mode_sm_assertions #(.RESET_DELAY(RESET_DELAY)) checks (
	.mclk, .rst_n, .regWr, .regRd, .regRdata, .intPullDown, .resetOutput_n,
	.mainSupplyEn, .failOutputs, .debugMode, .wdHalt, .wakeAccepted, .modeState
);

`default_nettype wire

// File: sim/board_model.sv
/*
 * board model: interrupt-pin fitting and main supply feedback.
 * assumes the pull-down and supply enable of the mode state machine.
 */
`timescale 1ns/1ps
`default_nettype none

module board_model (
	// clock
	input wire logic mclk,
	// fitting choices
	input wire logic pullUpFitted,
	input wire logic noisy,
	// device drive
	input wire logic intPullDown,
	input wire logic mainSupplyEn,
	// levels back to the device
	output logic intPinIn,
	output logic mainSupplyOk
);
	logic tog_q = 1'b0; // level of an undriven pin
	logic tog_d;
	logic [2:0] sup_q = 3'b111; // supply ramp stages
	logic [2:0] sup_d;

	// pattern flips each cycle; supply follows its enable late
	always_comb begin
		tog_d = !tog_q;
		sup_d = {sup_q[1:0], mainSupplyEn};
	end
	always_ff @(posedge mclk) begin
		tog_q <= tog_d;
		sup_q <= sup_d;
	end

	// pull-up beats the weak pull-down; a floating pin never settles
	always_comb begin
		if (noisy) intPinIn = tog_q;
		else if (pullUpFitted) intPinIn = 1'b1;
		else if (intPullDown) intPinIn = 1'b0;
		else intPinIn = tog_q;
	end
	assign mainSupplyOk = sup_q[2];
endmodule

`default_nettype wire

// File: sim/operating_mode_state_machine_tb_top.sv
/*
 * testbench of the operating-mode state machine: register tasks, events
 * and mode checks against a board model.
 * assumes short delay and window counts set below.
 */
`timescale 1ns/1ps
`default_nettype none

module operating_mode_state_machine_tb_top
	import mode_sm_pkg::*;
;
	localparam int unsigned DLY = 300; // shortened, but above the pin filter time
	localparam int unsigned WIN = 400; // shortened long window
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [15:0] regWdata = 16'h0000;
	logic [15:0] regRdata;
	logic [15:0] rv; // last word read
	logic regWr = 1'b0, regRd = 1'b0, mainSupplyOk, mainOvervoltage = 1'b0;
	logic wdFailIn = 1'b0, wdTrigger = 1'b0, wakeEvent = 1'b0, overtemp = 1'b0;
	logic debugSelectPin_n = 1'b1, intPinIn, pullUpFitted = 1'b1, noisy = 1'b0;
	logic intPullDown, resetOutput_n, mainSupplyEn, failOutputs;
	logic debugMode, wdHalt, wakeAccepted;
	logic [2:0] modeState;
	int badCount = 0;
	int nCompared = 0;

	always #5 mclk = ~mclk;

	operating_mode_state_machine #(.RESET_DELAY(DLY), .LONG_WINDOW(WIN)) dut (
		.mclk, .rst_n, .regAddr, .regWdata, .regWr, .regRd, .regRdata,
		.mainSupplyOk, .mainOvervoltage, .wdFailIn, .wdTrigger, .wakeEvent,
		.overtemp, .debugSelectPin_n, .intPinIn, .intPullDown, .resetOutput_n,
		.mainSupplyEn, .failOutputs, .debugMode, .wdHalt, .wakeAccepted, .modeState
	);
	board_model board (.mclk, .pullUpFitted, .noisy, .intPullDown, .mainSupplyEn,
		.intPinIn, .mainSupplyOk);

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", nCompared, badCount);
		if (badCount == 0 && nCompared > 0) $display("All tests passed");
		else $display("Some tests failed");
		$finish;
	endtask

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		nCompared++;
		if (seen !== exp) begin
			badCount++;
			$display("ERROR %0t: got %h want %h", $time, seen, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		@(posedge mclk);
		regAddr <= a;
		regWdata <= d;
		regWr <= 1'b1;
		@(posedge mclk);
		regWr <= 1'b0;
	endtask

	// read strobe for one cycle, data taken inside the following cycle
	task automatic rd(input logic [7:0] a);
		@(posedge mclk);
		regAddr <= a;
		regRd <= 1'b1;
		@(posedge mclk);
		regRd <= 1'b0;
		#1;
		rv = regRdata;
	endtask

	task automatic rdb(input logic [7:0] a, input int b, input logic e);
		rd(a);
		chk(16'(rv[b]), 16'(e));
	endtask

	// one level pulse: 0 watchdog failure, 1 overvoltage, 2 wake
	task automatic ev(input int k);
		@(posedge mclk);
		wdFailIn <= (k == 0);
		mainOvervoltage <= (k == 1);
		wakeEvent <= (k == 2);
		repeat (4) @(posedge mclk);
		{wdFailIn, mainOvervoltage, wakeEvent} <= 3'b000;
		repeat (4) @(posedge mclk);
	endtask

	// k is a mode code, or 8 for a released reset output
	function automatic logic hit(input int k);
		return (k == 8) ? (resetOutput_n === 1'b1) : (modeState === 3'(k));
	endfunction

	// bounded wait; running out is a mismatch and ends the run
	task automatic waitFor(input int k, input int lim);
		int i;
		i = 0;
		while (i < lim && !hit(k)) begin
			@(posedge mclk);
			#1;
			i++;
		end
		chk(16'(hit(k)), 16'h0001);
		if (!hit(k)) wrap_up();
	endtask

	initial begin
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (3) @(posedge mclk);
		#1;
		chk(16'(intPullDown), 16'h0001);
		chk(16'(modeState), 16'(MODE_INIT));
		ev(2);
		waitFor(8, DLY + 20);
		repeat (WIN - 40) @(posedge mclk);
		wdTrigger <= 1'b1;
		repeat (4) @(posedge mclk);
		wdTrigger <= 1'b0;
		repeat (60) @(posedge mclk);
		#1;
		chk(16'(modeState), 16'(MODE_INIT));
		rdb(8'h44, 6, 1'b1);
		waitFor(MODE_NORMAL, 4);
		$display("power-up test done");
		ev(1);
		rdb(8'h40, 1, 1'b1);
		chk(16'(failOutputs), 16'h0000);
		chk(16'(modeState), 16'(MODE_NORMAL));
		rdb(8'h40, 0, 1'b1);
		rd(8'h20);
		chk(rv, 16'h0000);
		$display("overvoltage flag test done");
		wr(8'h01, 16'h0080);
		waitFor(MODE_STOP, 8);
		@(posedge mclk);
		pullUpFitted <= 1'b0;
		ev(0);
		waitFor(MODE_RESTART, 8);
		chk(16'(failOutputs), 16'h0000);
		chk(16'(resetOutput_n), 16'h0000);
		waitFor(MODE_NORMAL, DLY + 20);
		rdb(8'h01, 7, 1'b0);
		rdb(8'h44, 6, 1'b0);
		$display("first failure test done");
		@(posedge mclk);
		overtemp <= 1'b1;
		ev(0);
		waitFor(MODE_FAILSAFE, 8);
		chk(16'(failOutputs), 16'h0001);
		chk(16'(mainSupplyEn), 16'h0000);
		repeat (30) @(posedge mclk);
		#1;
		chk(16'(modeState), 16'(MODE_FAILSAFE));
		ev(2);
		waitFor(MODE_NORMAL, DLY + 40);
		$display("fail-safe wake test done");
		wr(8'h0e, 16'h0048);
		rdb(8'h0e, 6, 1'b1);
		ev(1);
		waitFor(MODE_FAILSAFE, 8);
		@(posedge mclk);
		overtemp <= 1'b0;
		waitFor(MODE_NORMAL, DLY + 40);
		rdb(8'h40, 1, 1'b1);
		rdb(8'h44, 6, 1'b0);
		$display("overvoltage reset test done");
		@(posedge mclk);
		rst_n <= 1'b0;
		noisy <= 1'b1;
		pullUpFitted <= 1'b1;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		waitFor(MODE_RESTART, DLY + WIN + 40);
		chk(16'(failOutputs), 16'h0000);
		waitFor(MODE_NORMAL, DLY + 20);
		rdb(8'h44, 6, 1'b0);
		$display("missed window test done");
		@(posedge mclk);
		rst_n <= 1'b0;
		debugSelectPin_n <= 1'b0;
		repeat (5) @(posedge mclk);
		rst_n <= 1'b1;
		waitFor(8, DLY + 20);
		repeat (WIN + 20) @(posedge mclk);
		#1;
		chk(16'(modeState), 16'(MODE_INIT));
		chk(16'(debugMode), 16'h0001);
		chk(16'(wdHalt), 16'h0001);
		rdb(8'h43, 1, 1'b1);
		waitFor(MODE_NORMAL, 4);
		$display("debug test done");
		wrap_up();
	end
endmodule

`default_nettype wire
